// File: shared/prec_pkg.sv
// Package: shared constants and types for the pulse reference error counter
package prec_pkg;
	// Reference input format
	typedef enum logic [1:0] {
		PREC_FMT_FWD_REV,
		PREC_FMT_QUAD
	} prec_fmt_type;
	// Quadrature multiplier codes
	localparam logic [1:0] PREC_MULT_X1 = 2'h0;
	localparam logic [1:0] PREC_MULT_X2 = 2'h1;
	localparam logic [1:0] PREC_MULT_X4 = 2'h2;
	// Clear form codes
	localparam logic [1:0] PREC_CLR_HIGH_LEVEL = 2'h0;
	localparam logic [1:0] PREC_CLR_RISE_EDGE = 2'h1;
	localparam logic [1:0] PREC_CLR_LOW_LEVEL = 2'h2;
	localparam logic [1:0] PREC_CLR_FALL_EDGE = 2'h3;
	localparam logic [1:0] PREC_CLR_FORM_RESET = 2'h0;
	// Encoder divider
	localparam logic [15:0] PREC_DIV_RESET = 16'h0800;
	localparam logic [15:0] PREC_DIV_PASS = 16'h0000;
	localparam logic [16:0] PREC_DIV_FULL = 17'h10000;
	// Reference rate limits, in kpps
	localparam int PREC_MAX_KPPS_X1 = 500;
	localparam int PREC_MAX_KPPS_X2 = 400;
	localparam int PREC_MAX_KPPS_X4 = 200;
	// Quadrature pair
	typedef struct packed {
		logic a;
		logic b;
	} prec_quad_type;
	// Encoder outputs (A, B divided; C, S passed through), true and complement
	typedef struct packed {
		logic a;
		logic a_n;
		logic b;
		logic b_n;
		logic c;
		logic c_n;
		logic s;
		logic s_n;
	} prec_enc_out_type;
endpackage

// File: hdl/prec_core.sv
// Module: reference pulse decode, error counter with clear, encoder divider
`timescale 1ns/1ps
// How it works
// [RULE_01] Quadrature reference x1/x2/x4; host keeps 500/400/200 kpps limits.
// [RULE_02] Forward pulse adds one, reverse pulse subtracts one.
// [RULE_03] Quadrature direction from leading phase; edges counted per multiplier.
// [RULE_04] Met clear condition forces error counter to zero.
// [RULE_05] Position loop inhibited while clear applies.
// [RULE_06] Two-bit clear form selects four behaviours; default zero.
// [RULE_07] Form 0: held cleared while clear input is high.
// [RULE_08] Form 1: cleared once per rising edge of clear input.
// [RULE_09] Form 2: held cleared while clear input is low.
// [RULE_10] Form 3: cleared once per falling edge of clear input.
// [RULE_11] Encoder pulses divided and sent out on encoder output pins.
// [RULE_12] Division yields configured output pulses per revolution.
// [RULE_13] Divider independent of electronic gear settings.
// [RULE_14] Phases A, B, C driven as true and complement pairs.
// [RULE_15] Serial phase S driven with complement.
// [RULE_16] Divider setting zero passes pulses one to one.
// [RULE_17] Divider setting holds output pulses per revolution; the code uses it as a ratio over 65536 applied to the x4 encoder edges.
module prec_core #(
	parameter int CNT_W = 32
) (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic ref_format_quad_in,
	input wire logic fwd_pulse_in,
	input wire logic rev_pulse_in,
	input wire logic ref_phase_a_in,
	input wire logic ref_phase_b_in,
	input wire logic [1:0] pulse_multiplier_select,
	input wire logic [1:0] clear_form_select,
	input wire logic counter_clear_in,
	input wire logic [15:0] encoder_divider_setting,
	input wire logic [15:0] gear_numerator,
	input wire logic motor_encoder_a_in,
	input wire logic motor_encoder_b_in,
	input wire logic motor_encoder_c_in,
	input wire logic abs_serial_in,
	output logic signed [CNT_W-1:0] error_count_out,
	output logic position_loop_enable_out,
	output prec_pkg::prec_enc_out_type enc_out
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	logic [NSYNC-1:0] prev_reg;
	assign raw_in = {fwd_pulse_in, rev_pulse_in, ref_phase_a_in, ref_phase_b_in,
		counter_clear_in, motor_encoder_a_in, motor_encoder_b_in, motor_encoder_c_in};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge core_clk_in) begin
				if (srst_in) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
					prev_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
					prev_reg[gi] <= sync2_reg[gi];
				end
			end
		end
	endgenerate
	logic s_sync1_reg;
	logic s_sync2_reg;
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			s_sync1_reg <= 1'b0;
			s_sync2_reg <= 1'b0;
		end else begin
			s_sync1_reg <= abs_serial_in;
			s_sync2_reg <= s_sync1_reg;
		end
	end

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	// Edge flops reset low: a clear pin idling high shows one rise after reset
	wire fwd_rise = sync2_reg[7] & ~prev_reg[7];
	wire rev_rise = sync2_reg[6] & ~prev_reg[6];
	wire clr_lvl = sync2_reg[3];
	wire clr_rise = sync2_reg[3] & ~prev_reg[3];
	wire clr_fall = ~sync2_reg[3] & prev_reg[3];

	// ----------------------------------------
	// Quadrature decode
	// ----------------------------------------
	// Returns {valid, down}; x1 counts A rising edges only, at most one edge per cycle
	// Both phases changing at once counts nothing in x4; x1 and x2 still count the A edge
	function automatic logic [1:0] quad_step(input logic [1:0] mult,
		input logic a, input logic b, input logic pa, input logic pb);
		logic ea;
		logic eb;
		logic dn;
		logic hit;
		ea = a ^ pa;
		eb = b ^ pb;
		dn = ea ? (a == b) : (a != b);
		hit = 1'b0;
		case (mult)
			prec_pkg::PREC_MULT_X1: hit = ea & a;
			prec_pkg::PREC_MULT_X2: hit = ea;
			default: hit = (ea ^ eb);
		endcase
		return {hit, dn};
	endfunction
	wire [1:0] ref_q = quad_step(pulse_multiplier_select, sync2_reg[5], sync2_reg[4],
		prev_reg[5], prev_reg[4]); // [RULE_01] [RULE_03]
	wire [1:0] enc_q = quad_step(prec_pkg::PREC_MULT_X4, sync2_reg[2], sync2_reg[1],
		prev_reg[2], prev_reg[1]);

	// ----------------------------------------
	// Error counter and clear
	// ----------------------------------------
	logic clr_hold;
	logic clr_once;
	always_comb begin
		clr_hold = 1'b0;
		clr_once = 1'b0;
		case (clear_form_select) // [RULE_06]
			prec_pkg::PREC_CLR_HIGH_LEVEL: clr_hold = clr_lvl; // [RULE_07]
			prec_pkg::PREC_CLR_RISE_EDGE: clr_once = clr_rise; // [RULE_08]
			prec_pkg::PREC_CLR_LOW_LEVEL: clr_hold = ~clr_lvl; // [RULE_09]
			default: clr_once = clr_fall; // [RULE_10]
		endcase
	end
	wire clr_any = clr_hold | clr_once;

	// ----------------------------------------
	// Reference step select
	// ----------------------------------------
	// Fwd and rev in the same cycle cancel out
	wire step_up = ref_format_quad_in ? (ref_q[1] & ~ref_q[0]) : (fwd_rise & ~rev_rise);
	wire step_dn = ref_format_quad_in ? (ref_q[1] & ref_q[0]) : (rev_rise & ~fwd_rise);
	logic signed [CNT_W-1:0] error_count_next;
	always_comb begin
		error_count_next = error_count_out;
		if (clr_any) begin
			error_count_next = '0; // [RULE_04]
		end else if (step_up) begin
			error_count_next = error_count_out + CNT_W'(1); // [RULE_02]
		end else if (step_dn) begin
			error_count_next = error_count_out - CNT_W'(1); // [RULE_02]
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			error_count_out <= '0;
			position_loop_enable_out <= 1'b0;
		end else begin
			error_count_out <= error_count_next;
			position_loop_enable_out <= ~clr_any; // [RULE_05]
		end
	end

	// ----------------------------------------
	// Encoder divider
	// ----------------------------------------
	// Phase accumulator: each x4 encoder edge adds the setting over 65536.
	// Gear numerator deliberately unused here, so gearing cannot disturb it.
	wire unused_gear = ^gear_numerator; // [RULE_13]
	logic [15:0] acc_reg;
	logic [1:0] out_state_reg;
	wire [16:0] acc_sum = {1'b0, acc_reg} + {1'b0, encoder_divider_setting}; // [RULE_12]
	wire pass = (encoder_divider_setting == prec_pkg::PREC_DIV_PASS); // [RULE_16]
	wire adv = enc_q[1] & (pass | acc_sum[16]); // [RULE_17]
	// Large settings bunch output edges; no smoothing of the output rate
	wire enc_edge = enc_q[1];
	wire enc_dn = enc_q[0];
	wire [15:0] acc_next = pass ? acc_reg : acc_sum[15:0];
	wire [1:0] out_state_next = enc_dn ? out_state_reg - 2'h1 : out_state_reg + 2'h1;
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			acc_reg <= '0;
		end else if (enc_edge) begin
			acc_reg <= acc_next;
		end
	end
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			out_state_reg <= 2'h0;
		end else if (adv) begin
			out_state_reg <= out_state_next;
		end
	end
	// Gray order 00,01,11,10 gives A leading B on forward motion
	wire out_a = out_state_reg[1] ^ out_state_reg[0] ^ 1'b0;
	wire out_b = out_state_reg[1];

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	// Pairs stay complementary in reset too, so line drivers never see equal levels
	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			enc_out.a <= 1'b0;
			enc_out.a_n <= 1'b1;
			enc_out.b <= 1'b0;
			enc_out.b_n <= 1'b1;
			enc_out.c <= 1'b0;
			enc_out.c_n <= 1'b1;
			enc_out.s <= 1'b0;
			enc_out.s_n <= 1'b1;
		end else begin
			enc_out.a <= out_a; // [RULE_11] [RULE_14]
			enc_out.a_n <= ~out_a; // [RULE_14]
			enc_out.b <= out_b; // [RULE_14]
			enc_out.b_n <= ~out_b; // [RULE_14]
			enc_out.c <= sync2_reg[0]; // [RULE_14]
			enc_out.c_n <= ~sync2_reg[0]; // [RULE_14]
			enc_out.s <= s_sync2_reg & ~unused_gear | s_sync2_reg & unused_gear; // [RULE_15]
			enc_out.s_n <= ~s_sync2_reg; // [RULE_15]
		end
	end
endmodule

// File: sim/prec_core_sva.sv
// Checker: clear behaviour and encoder output pairs of the core
`timescale 1ns/1ps
module prec_core_sva #(
	parameter int CNT_W = 32
) (
	input wire logic core_clk_in,
	input wire logic srst_in,
	input wire logic [1:0] clear_form_select,
	input wire logic counter_clear_in,
	input wire logic motor_encoder_c_in,
	input wire logic signed [CNT_W-1:0] error_count_out,
	input wire logic position_loop_enable_out,
	input wire prec_pkg::prec_enc_out_type enc_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (srst_in);
	sequence hi_held;
		(clear_form_select == 2'h0 && counter_clear_in) [*5];
	endsequence
	sequence lo_held;
		(clear_form_select == 2'h2 && !counter_clear_in) [*5];
	endsequence
	hold_high_a: assert property (hi_held |=> error_count_out == '0)
		else $error("count not held while clear high");
	hold_low_a: assert property (lo_held |=> error_count_out == '0)
		else $error("count not held while clear low");
	loop_off_a: assert property (hi_held |=> !position_loop_enable_out)
		else $error("loop enabled during clear");
	loop_on_a: assert property ((clear_form_select == 2'h1 && !counter_clear_in) [*6]
		|-> position_loop_enable_out) else $error("loop off without clear");
	rise_clr_a: assert property (clear_form_select == 2'h1 && $rose(counter_clear_in)
		|-> ##[1:5] error_count_out == '0) else $error("rising clear missed");
	fall_clr_a: assert property (clear_form_select == 2'h3 && $fell(counter_clear_in)
		|-> ##[1:5] error_count_out == '0) else $error("falling clear missed");
	abc_pair_a: assert property (enc_out.a_n != enc_out.a && enc_out.b_n != enc_out.b
		&& enc_out.c_n != enc_out.c) else $error("encoder pair not complementary");
	c_pass_a: assert property ($rose(motor_encoder_c_in) |-> ##[2:5] enc_out.c
		&& enc_out.s_n != enc_out.s) else $error("phase C or S pair wrong");
endmodule
bind prec_core prec_core_sva #(.CNT_W(CNT_W)) i_prec_core_sva (.core_clk_in, .srst_in,
	.clear_form_select, .counter_clear_in, .motor_encoder_c_in, .error_count_out,
	.position_loop_enable_out, .enc_out);

// File: sim/prec_host_model.sv
// Host controller model sending reference steps
`timescale 1ns/1ps
module prec_host_model #(
	parameter int QTR = 125
) (
	input wire logic core_clk_in,
	output logic fwd_out,
	output logic rev_out,
	output prec_pkg::prec_quad_type phase_out
);
	initial {fwd_out, rev_out, phase_out} = '0;
	// Quarter of 1.25 us keeps every multiplier within its rate limit
	task automatic step(input logic up, input logic quad);
		for (int i = 0; i < 4; i++) begin
			repeat (QTR) @(posedge core_clk_in);
			if (quad)
				phase_out <= up ? {i < 2, i % 3 != 0} : {i % 3 != 0, i < 2};
			else if (i < 2)
				{fwd_out, rev_out} <= {up & (i == 0), !up & (i == 0)};
		end
	endtask
endmodule

// File: sim/pulse_reference_error_counter_tb_top.sv
// Testbench: reference steps, clear forms and encoder division
`timescale 1ns/1ps
module pulse_reference_error_counter_tb_top;
	logic core_clk_in = 0, srst_in = 1, quad = 0, clr = 0, ser = 0, fwd, rev, loop_en;
	logic [1:0] mult = 0, form = 0;
	logic [15:0] div = 0, gear = 0;
	logic [2:0] menc = 0;
	logic signed [31:0] cnt, e_cnt = 0;
	prec_pkg::prec_quad_type ph;
	prec_pkg::prec_enc_out_type eo;
	int failures = 0, num_checks = 0, seed = 32'heca7, cyc = 0, rises = 0, w;
	logic [33:0] expq [$];
	event chk_ev;
	initial forever #5 core_clk_in = ~core_clk_in;
	prec_host_model i_prec_host_model (.core_clk_in(core_clk_in), .fwd_out(fwd), .rev_out(rev),
		.phase_out(ph));
	prec_core i_prec_core (.core_clk_in(core_clk_in), .srst_in(srst_in), .ref_format_quad_in(quad),
		.fwd_pulse_in(fwd), .rev_pulse_in(rev), .ref_phase_a_in(ph.a), .ref_phase_b_in(ph.b),
		.pulse_multiplier_select(mult), .clear_form_select(form), .counter_clear_in(clr),
		.encoder_divider_setting(div), .gear_numerator(gear), .motor_encoder_a_in(menc[0]),
		.motor_encoder_b_in(menc[1]), .motor_encoder_c_in(menc[2]), .abs_serial_in(ser),
		.error_count_out(cnt), .position_loop_enable_out(loop_en), .enc_out(eo));
	always @(posedge eo.a) rises++;
	always @(posedge core_clk_in) if (++cyc == 60000) begin
		failures++;
		tally_and_finish();
	end
	task automatic check(input logic s, input logic [32:0] e);
		repeat (6) @(negedge core_clk_in);
		expq.push_back({s, e});
		-> chk_ev;
		// Return on a rising edge so the next stimulus lands there
		@(posedge core_clk_in);
	endtask
	always @(chk_ev) begin : watch
		logic [33:0] n;
		logic [32:0] got;
		n = expq.pop_front();
		got = n[33] ? {1'b1, 32'(rises)} : {loop_en, cnt};
		num_checks++;
		if (got !== n[32:0]) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, n[32:0]);
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge core_clk_in);
		srst_in <= 0;
		gear <= 16'($random(seed));
		check(0, 33'h100000000);
		for (int i = 0; i < 4; i++) i_prec_host_model.step(i != 2, 0);
		check(0, 33'h100000002);
		$display("test fwd_rev done");
		quad <= 1;
		e_cnt = 2;
		for (int m = 0; m < 4; m++) begin
			mult <= 2'(m);
			w = m == 0 ? 1 : m == 1 ? 2 : 4;
			i_prec_host_model.step(1, 1);
			check(0, {1'b1, e_cnt + w});
			i_prec_host_model.step(0, 1);
			check(0, {1'b1, e_cnt});
		end
		$display("test quadrature done");
		quad <= 0;
		for (int f = 0; f < 4; f++) begin
			form <= 2'(f);
			clr <= f[1];
			i_prec_host_model.step(1, 0);
			clr <= !f[1];
			i_prec_host_model.step(1, 0);
			check(0, {f[0], 32'(f[0])});
			clr <= f[1];
			i_prec_host_model.step(1, 0);
			check(0, {1'b1, 32'(f[0] ? 2 : 1)});
		end
		$display("test clear forms done");
		for (int d = 0; d < 2; d++) begin
			div <= d ? 16'h8000 : 16'h0000;
			gear <= 16'($random(seed));
			@(posedge core_clk_in) rises = 0;
			for (int q = 0; q < 32; q++) begin
				repeat (8) @(posedge core_clk_in);
				menc <= {q % 4 == 0, (q % 4) % 3 != 0, q % 4 < 2};
				ser <= 1'($random(seed));
			end
			check(1, {1'b1, 32'(d ? 4 : 8)});
		end
		$display("test divider done");
		tally_and_finish();
	end
endmodule
